// [verilog/cacc_params.svh]
// constants of the counter array: timing, field positions, reset values
// assumes a 50 MHz system clock standing in for the oscillator
`ifndef CACC_PARAMS_SVH
`define CACC_PARAMS_SVH
`define CACC_NUM_MODULES      5
`define CACC_WDT_MODULE       4
`define CACC_OSC_DIV          6
`define CACC_EXT_MIN_DIV      4
`define CACC_SRC_OSC0         2'h0
`define CACC_SRC_OSC1         2'h1
`define CACC_SRC_T0           2'h2
`define CACC_SRC_EXT          2'h3
`define CACC_CNT_RESET        16'h0000
`define CACC_BYTE_RESET       8'h00
`define CACC_LOW_WRAP         8'hFF
`endif

// [verilog/cacc_pkg.sv]
// types shared by the counter array design
// assumes cacc_params.svh on the include path
package cacc_pkg;
    typedef logic [15:0] cacc_word_t;
    typedef logic [7:0]  cacc_byte_t;
    typedef logic [1:0]  cacc_src_t;
    typedef enum logic [1:0]
    {
        CACC_IDLE  = 2'b00,
        CACC_RUN   = 2'b01
    } cacc_run_e;
endpackage : cacc_pkg

// [verilog/cacc_module.sv]
// one compare/capture module of the counter array
// assumes the top supplies a count pulse, counter value and synced reset
`include "cacc_params.svh"
module cacc_module
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_q_b,
    // shared counter
    input  wire cacc_pkg::cacc_word_t count,
    input  wire logic               count_tick,
    input  wire logic               low_wrap,
    // mode bits
    input  wire logic               compare_en,
    input  wire logic               capture_rise_en,
    input  wire logic               capture_fall_en,
    input  wire logic               match_en,
    input  wire logic               toggle_en,
    input  wire logic               pwm_en,
    // software access to compare bytes
    input  wire logic               cmp_wr,
    input  wire cacc_pkg::cacc_word_t cmp_wdata,
    // pin
    input  wire logic               module_pin_in,
    // results
    output logic                    event_set,
    output logic                    match_hit,
    output cacc_pkg::cacc_byte_t    compare_high_byte,
    output cacc_pkg::cacc_byte_t    compare_low_byte,
    output logic                    pin_out
);
    import cacc_pkg::*;

    logic pin_q;
    logic pin_out_d;
    wire  rise_w;
    wire  fall_w;
    wire  capture_w;
    wire  pwm_mode_w;
    wire  hs_mode_w;
    wire  equal_w;

    // mode decode and edge qualification
    assign rise_w     = module_pin_in & ~pin_q;
    assign fall_w     = ~module_pin_in & pin_q;
    assign capture_w  = (capture_rise_en & rise_w)
                      | (capture_fall_en & fall_w);
    assign pwm_mode_w = pwm_en & compare_en;
    assign hs_mode_w  = toggle_en & match_en & compare_en;
    assign equal_w    = count_tick
                      && (count == {compare_high_byte, compare_low_byte});
    assign match_hit  = equal_w & compare_en & match_en & ~pwm_en;
    assign event_set  = match_hit | capture_w;

    // pwm level and toggle selection
    always_comb
    begin
        pin_out_d = pin_out;
        if (pwm_mode_w)
            pin_out_d = (count[7:0] >= compare_low_byte);
        else if (hs_mode_w && equal_w)
            pin_out_d = ~pin_out;
    end

    // pin history and output
    always_ff @(posedge clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
        begin
            pin_q   <= 1'b0;
            pin_out <= 1'b1;
        end
        else
        begin
            pin_q   <= module_pin_in;
            pin_out <= pin_out_d;
        end
    end

    // compare bytes: software write, capture, pwm reload
    always_ff @(posedge clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
        begin
            compare_high_byte <= `CACC_BYTE_RESET;
            compare_low_byte  <= `CACC_BYTE_RESET;
        end
        else if (capture_w)
        begin
            compare_high_byte <= count[15:8];
            compare_low_byte  <= count[7:0];
        end
        else if (cmp_wr)
        begin
            compare_high_byte <= cmp_wdata[15:8];
            compare_low_byte  <= cmp_wdata[7:0];
        end
        else if (pwm_mode_w && low_wrap)
            compare_low_byte <= compare_high_byte;
    end
endmodule : cacc_module

// [verilog/cacc_top.sv]
// counter array: shared 16-bit counter, five compare/capture modules,
// module 4 watchdog
// assumes inputs synchronous to clk; software bits arrive as plain ports
// What this block does
// - either capture edge select enables capture
// - valid edge copies counter into compare bytes
// - irq when flag and enable both set
// - compare plus match, with pwm bit clear, sets flag on equality
// - high speed mode toggles pin on match
// - toggle needs toggle, match, compare enables
// - pwm shares counter frequency, duty per module
// - pwm pin low below compare, else high
// - low byte wrap reloads low from high
// - pwm needs pwm and compare bits
// - only module 4 may be watchdog
// - watchdog match raises internal reset
// - watchdog reset never drives external pin
// - event flag sticky until software clears
// - counter runs only while run bit set
// - source: osc/6, timer0 overflow, external
`include "cacc_params.svh"
module cacc_top
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // counter control
    input  wire logic                  counter_run,
    input  wire cacc_pkg::cacc_src_t   count_source_sel,
    input  wire logic                  watchdog_en,
    input  wire logic                  timer0_ovf,
    input  wire logic                  ext_count_input,
    input  wire logic                  counter_wr,
    input  wire cacc_pkg::cacc_word_t  counter_wdata,
    // module mode bits, one bit per module
    input  wire logic [4:0]            compare_en,
    input  wire logic [4:0]            capture_rise_en,
    input  wire logic [4:0]            capture_fall_en,
    input  wire logic [4:0]            match_en,
    input  wire logic [4:0]            toggle_en,
    input  wire logic [4:0]            pwm_en,
    input  wire logic [4:0]            module_irq_en,
    // compare writes and flag clears
    input  wire logic [4:0]            cmp_wr,
    input  wire cacc_pkg::cacc_word_t  cmp_wdata,
    input  wire logic [4:0]            flag_clr,
    // pins
    input  wire logic [4:0]            module_pin_in,
    output logic [4:0]                 module_pin_out,
    // status
    output cacc_pkg::cacc_byte_t       counter_high_byte,
    output cacc_pkg::cacc_byte_t       counter_low_byte,
    output logic [4:0]                 module_event_flag,
    output logic                       irq_req,
    output logic                       wdt_reset_req,
    output logic [39:0]                compare_bytes
);
    import cacc_pkg::*;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_s1_q;
    logic rst_q_b;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_q <= 1'b0;
            rst_q_b  <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_q_b  <= rst_s1_q;
        end
    end

    // ----------------------------------------
    // count pulse source
    // ----------------------------------------
    logic [2:0] div_q;
    logic       ext_q;
    logic       ext_gap_q;
    wire        osc_tick_w;
    wire        ext_tick_w;
    wire        src_tick_w;
    wire        count_tick_w;
    wire        low_wrap_w;
    cacc_word_t count_q;
    cacc_word_t count_d;

    assign osc_tick_w = (div_q == 3'(`CACC_OSC_DIV - 1));
    // external edge, spaced at least the minimum divide apart
    assign ext_tick_w = ext_count_input & ~ext_q & ext_gap_q;
    assign src_tick_w = (count_source_sel == `CACC_SRC_T0)  ? timer0_ovf :
                        (count_source_sel == `CACC_SRC_EXT) ? ext_tick_w :
                                                              osc_tick_w;
    assign count_tick_w = counter_run & src_tick_w;
    assign low_wrap_w   = count_tick_w && (count_q[7:0] == `CACC_LOW_WRAP);
    assign count_d      = count_q + 16'h0001;

    // divider for the oscillator rate
    always_ff @(posedge clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
            div_q <= 3'h0;
        else if (osc_tick_w)
            div_q <= 3'h0;
        else
            div_q <= div_q + 3'h1;
    end

    // external input history and spacing
    logic [1:0] ext_cnt_q;
    always_ff @(posedge clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
        begin
            ext_q     <= 1'b0;
            ext_cnt_q <= 2'h0;
            ext_gap_q <= 1'b1;
        end
        else
        begin
            ext_q <= ext_count_input;
            if (ext_tick_w)
            begin
                ext_cnt_q <= 2'h0;
                ext_gap_q <= 1'b0;
            end
            else if (!ext_gap_q)
            begin
                ext_cnt_q <= ext_cnt_q + 2'h1;
                ext_gap_q <= (ext_cnt_q == 2'(`CACC_EXT_MIN_DIV - 2));
            end
        end
    end

    always_ff @(posedge clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
            count_q <= `CACC_CNT_RESET;
        else if (counter_wr)
            count_q <= counter_wdata;
        else if (count_tick_w)
            count_q <= count_d;
    end

    // ----------------------------------------
    // modules
    // ----------------------------------------
    logic [4:0] event_w;
    logic [4:0] match_w;
    logic [4:0] pin_w;
    cacc_byte_t hi_w [5];
    cacc_byte_t lo_w [5];

    genvar gi;
    generate
        for (gi = 0; gi < `CACC_NUM_MODULES; gi++)
        begin : g_mod
            cacc_module u_mod
            (
                .clk               (clk),
                .rst_q_b           (rst_q_b),
                .count             (count_q),
                .count_tick        (count_tick_w),
                .low_wrap          (low_wrap_w),
                .compare_en        (compare_en[gi]),
                .capture_rise_en   (capture_rise_en[gi]),
                .capture_fall_en   (capture_fall_en[gi]),
                .match_en          (match_en[gi]),
                .toggle_en         (toggle_en[gi]),
                .pwm_en            (pwm_en[gi]),
                .cmp_wr            (cmp_wr[gi]),
                .cmp_wdata         (cmp_wdata),
                .module_pin_in     (module_pin_in[gi]),
                .event_set         (event_w[gi]),
                .match_hit         (match_w[gi]),
                .compare_high_byte (hi_w[gi]),
                .compare_low_byte  (lo_w[gi]),
                .pin_out           (pin_w[gi])
            );
            assign compare_bytes[gi*8 +: 8] = lo_w[gi];
        end
    endgenerate

    // ----------------------------------------
    // flags, interrupt, watchdog
    // ----------------------------------------
    wire [4:0] flag_d;
    wire       irq_d;
    wire       wdt_d;

    assign flag_d = event_w | (module_event_flag & ~flag_clr);
    assign irq_d  = |(flag_d & module_irq_en);
    // module 4 only, gated by enable
    assign wdt_d  = watchdog_en & compare_en[`CACC_WDT_MODULE]
                  & match_w[`CACC_WDT_MODULE];

    // status registers
    always_ff @(posedge clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
        begin
            module_event_flag <= 5'h00;
            irq_req           <= 1'b0;
            wdt_reset_req     <= 1'b0;
            module_pin_out    <= 5'h1F;
            counter_high_byte <= `CACC_BYTE_RESET;
            counter_low_byte  <= `CACC_BYTE_RESET;
        end
        else
        begin
            module_event_flag <= flag_d;
            irq_req           <= irq_d;
            wdt_reset_req     <= wdt_d;
            module_pin_out    <= pin_w;
            counter_high_byte <= count_q[15:8];
            counter_low_byte  <= count_q[7:0];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_flag_sticky;
        @(posedge clk) disable iff (!rst_q_b)
        module_event_flag[0] && !flag_clr[0] |=> module_event_flag[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("event flag dropped without clear");

    property p_irq;
        @(posedge clk) disable iff (!rst_q_b)
        irq_req == |(module_event_flag & $past(module_irq_en));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request wrong");

    property p_stop;
        @(posedge clk) disable iff (!rst_q_b)
        !counter_run && !counter_wr |=> $stable(count_q);
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter moved while stopped");

    property p_wdt;
        @(posedge clk) disable iff (!rst_q_b)
        !watchdog_en |=> !wdt_reset_req;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog reset while disabled");

    property p_wdt_hit;
        @(posedge clk) disable iff (!rst_q_b)
        wdt_d |=> wdt_reset_req && module_event_flag[4];
    endproperty
    a_wdt_hit: assert property (p_wdt_hit)
        else $error("watchdog match missed");

    property p_pwm;
        @(posedge clk) disable iff (!rst_q_b)
        pwm_en[3] && compare_en[3]
        |=> ##1 module_pin_out[3]
                == ($past(count_q[7:0], 2) >= $past(lo_w[3], 2));
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("pwm level wrong");

    property p_capture;
        @(posedge clk) disable iff (!rst_q_b)
        event_w[1] && !match_w[1] |=> {hi_w[1], lo_w[1]} == $past(count_q);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture value wrong");

    property p_tick;
        @(posedge clk) disable iff (!rst_q_b)
        count_tick_w && !counter_wr |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_tick: assert property (p_tick)
        else $error("counter increment wrong");
endmodule : cacc_top

// [test/cacc_pin_model.sv]
// far-side model: capture pins, external count input, timer0 overflow
// assumes pin levels are commanded by the bench; changes at falling edge
module cacc_pin_model
(
    // clock
    input  wire logic       clk,
    // commanded pin levels
    input  wire logic [4:0] pin_cmd,
    // driven pins
    output logic [4:0]      module_pin_in,
    output logic            ext_count_input,
    output logic            timer0_ovf
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [5:0] cyc_q;
    logic [4:0] cmd_q;

    // commanded levels taken at the rising edge, where they are settled
    always @(posedge clk)
        cmd_q <= pin_cmd;

    // quiet start before the first edge
    initial
    begin
        cyc_q = 6'h00;
        module_pin_in = 5'h00;
        ext_count_input = 1'b0;
        timer0_ovf = 1'b0;
    end

    // ext spacing: count pulses every 5 clocks, overflow every 7
    always @(negedge clk)
    begin
        cyc_q <= (cyc_q == 6'h22) ? 6'h00 : cyc_q + 6'h01;
        ext_count_input <= (cyc_q % 5) == 0;
        timer0_ovf <= (cyc_q % 7) == 0;
        module_pin_in <= cmd_q;
    end
endmodule : cacc_pin_model

// [test/cacc_top_tb.sv]
// self-checking bench for the counter array top
// assumes cacc_top, cacc_pkg and cacc_pin_model compiled before it
module cacc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cacc_pkg::*;

    logic        clk, rst_b, counter_run, watchdog_en, counter_wr;
    cacc_src_t   sel;
    cacc_word_t  counter_wdata, cmp_wdata, v, c0;
    logic [4:0]  ce, cr, cf, me, te, pe, ie, cmp_wr, flag_clr, pin_cmd;
    logic [4:0]  pin_in, pin_out, flag;
    logic        ext_in, t0, irq, wdt, p0;
    cacc_byte_t  cnt_h, cnt_l, h, l;
    logic [39:0] cbytes;
    int          n_fail = 0;
    int          compares = 0;
    int          n_wdt = 0;

    cacc_top u_dut
    (
        .clk(clk), .rst_b(rst_b), .counter_run(counter_run),
        .count_source_sel(sel), .watchdog_en(watchdog_en),
        .timer0_ovf(t0), .ext_count_input(ext_in),
        .counter_wr(counter_wr), .counter_wdata(counter_wdata),
        .compare_en(ce), .capture_rise_en(cr), .capture_fall_en(cf),
        .match_en(me), .toggle_en(te), .pwm_en(pe), .module_irq_en(ie),
        .cmp_wr(cmp_wr), .cmp_wdata(cmp_wdata), .flag_clr(flag_clr),
        .module_pin_in(pin_in), .module_pin_out(pin_out),
        .counter_high_byte(cnt_h), .counter_low_byte(cnt_l),
        .module_event_flag(flag), .irq_req(irq), .wdt_reset_req(wdt),
        .compare_bytes(cbytes)
    );

    cacc_pin_model u_pins
    (
        .clk(clk), .pin_cmd(pin_cmd), .module_pin_in(pin_in),
        .ext_count_input(ext_in), .timer0_ovf(t0)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [15:0] e, g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", what, e, g);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic load(input cacc_word_t w);
        counter_wdata = w;
        counter_wr = 1'b1;
        tick(1);
        counter_wr = 1'b0;
        tick(1);
    endtask : load

    task automatic wcmp(input int m, input cacc_word_t w);
        cmp_wdata = w;
        cmp_wr[m] = 1'b1;
        tick(1);
        cmp_wr = 5'h00;
        tick(1);
    endtask : wcmp

    // run the counter for about n steps of clk/6, then stop it
    task automatic runc(input int n);
        counter_run = 1'b1;
        tick(6 * n);
        counter_run = 1'b0;
        tick(3);
    endtask : runc

    function automatic int per(input int s);
        return (s == 2) ? 7 : (s == 3) ? 5 : 6;
    endfunction : per

    function automatic logic [15:0] pwm_exp(input cacc_byte_t lo, cl);
        return {15'h0000, lo >= cl};
    endfunction : pwm_exp

    // clock generation
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // count watchdog reset pulses
    always @(negedge clk)
        if (wdt === 1'b1)
            n_wdt++;

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h31BD00B4));
        {counter_run, watchdog_en, counter_wr, sel} = '0;
        {ce, cr, cf, me, te, pe, ie, cmp_wr, flag_clr, pin_cmd} = '0;
        counter_wdata = 16'h0000;
        cmp_wdata = 16'h0000;
        rst_b = 1'b0;
        tick(16);
        rst_b = 1'b1;
        tick(4);
        chk("irq_rst", 16'h0000, {15'h0000, irq});
        // step rate per source, then hold when stopped
        for (int s = 0; s < 4; s++)
        begin
            sel = 2'(s);
            counter_run = 1'b1;
            tick(3);
            c0 = {cnt_h, cnt_l};
            tick(10 * per(s));
            chk("rate", 16'h000A, {cnt_h, cnt_l} - c0);
        end
        sel = 2'h0;
        counter_run = 1'b0;
        tick(3);
        c0 = {cnt_h, cnt_l};
        tick(40);
        chk("stop", c0, {cnt_h, cnt_l});
        for (int i = 0; i < 3; i++)
        begin
            v = 16'($urandom) & 16'h7FFF;
            load(v);
            for (int m = 0; m < 3; m++)
                wcmp(m, v + 16'h0002);
            {ce, me, te} = {5'h05, 5'h07, 5'h06};
            p0 = pin_out[2];
            runc(5);
            chk("timer", 16'h0005, {11'h000, flag});
            chk("toggle", {15'h0000, ~p0}, {15'h0000, pin_out[2]});
            chk("gated", 16'h0001, {15'h0000, pin_out[1]});
            chk("irq_off", 16'h0000, {15'h0000, irq});
            ie[0] = 1'b1;
            tick(2);
            chk("irq_on", 16'h0001, {15'h0000, irq});
            tick(20);
            chk("sticky", 16'h0001, {15'h0000, flag[0]});
            flag_clr = 5'h05;
            tick(1);
            flag_clr = 5'h00;
            tick(2);
            chk("cleared", 16'h0000, {11'h000, flag});
            chk("irq_clr", 16'h0000, {15'h0000, irq});
            {ce, me, te, ie} = '0;
        end
        // capture on rising then falling pin edge
        for (int e = 0; e < 2; e++)
        begin
            v = 16'($urandom);
            pin_cmd[1] = e[0];
            tick(4);
            load(v);
            cr[1] = 1'b1; // second pass: capture on either edge
            cf[1] = e[0];
            tick(3);
            chk("no_edge", 16'h0000, {15'h0000, flag[1]});
            pin_cmd[1] = ~e[0];
            tick(6);
            chk("cap_flag", 16'h0001, {15'h0000, flag[1]});
            chk("cap_low", {8'h00, v[7:0]}, {8'h00, cbytes[15:8]});
            {cr, cf} = '0;
            flag_clr[1] = 1'b1;
            tick(1);
            flag_clr = 5'h00;
            tick(1);
        end
        // duty at the compare boundary, pwm needs compare
        h = 8'($urandom);
        l = 8'($urandom_range(254, 1));
        if (h == l)
            h = ~l;
        pe = 5'h09;
        ce[3] = 1'b1;
        wcmp(3, {h, l});
        wcmp(0, {h, l});
        for (int k = 0; k < 2; k++)
        begin
            load({8'h00, l - 8'h01 + 8'(k)});
            tick(4);
            chk("pwm", pwm_exp(l - 8'h01 + 8'(k), l),
                {15'h0000, pin_out[3]});
            chk("pwm_off", 16'h0001, {15'h0000, pin_out[0]});
        end
        // reload of the low byte at the low-byte wrap
        load(16'h00FD);
        runc(6);
        chk("reload", {8'h00, h}, {8'h00, cbytes[31:24]});
        {pe, ce} = '0;
        // module 4 as plain timer while watchdog is off
        ce[4] = 1'b1;
        me[4] = 1'b1;
        v = 16'h1000;
        load(v);
        wcmp(4, v + 16'h0002);
        runc(5);
        chk("wdt_off", 16'h0000, 16'(n_wdt));
        chk("m4_flag", 16'h0001, {15'h0000, flag[4]});
        // software moves the compare ahead to hold off reset
        watchdog_en = 1'b1;
        load(v);
        wcmp(4, v + 16'h0003);
        runc(1);
        wcmp(4, v + 16'h0028);
        runc(5);
        chk("wdt_held", 16'h0000, 16'(n_wdt));
        // left alone, the match gives one reset pulse
        counter_run = 1'b1;
        for (int j = 0; j < 400 && n_wdt == 0; j++)
            tick(1);
        counter_run = 1'b0;
        watchdog_en = 1'b0;
        tick(3);
        chk("wdt_fire", 16'h0001, 16'(n_wdt));
        report_and_stop();
    end
endmodule : cacc_top_tb
